// >>> src/asc_decode.sv
`timescale 1ns/1ns
`default_nettype none
module asc_decode
(
   input  wire logic [15:0] cfg_i,
   output logic      [2:0]  gain_o,
   output logic      [15:0] pos_onehot_o,
   output logic      [1:0]  neg_sel_o
);
   logic [3:0] pos;
   assign pos = cfg_i[asc_pkg::POS_HI:asc_pkg::POS_LO];

   always_comb
   begin
      case (cfg_i[asc_pkg::GAIN_HI:asc_pkg::GAIN_LO])
         2'h0:    gain_o = asc_pkg::GAIN_X1;
         2'h1:    gain_o = asc_pkg::GAIN_X2;
         default: gain_o = asc_pkg::GAIN_X4;
      endcase
   end

   genvar g;
   generate
      for (g = 0; g < 16; g++)
      begin : g_pos
         assign pos_onehot_o[g] = (pos == 4'(g));
      end
   endgenerate

   always_comb
   begin
      if (pos >= asc_pkg::POS_INTERNAL_MIN)
         neg_sel_o = asc_pkg::NEG_AUTO;
      else if (cfg_i[asc_pkg::NEG_POS])
         neg_sel_o = asc_pkg::NEG_EXT7;
      else
         neg_sel_o = asc_pkg::NEG_AGND;
   end
endmodule
`default_nettype wire

// >>> src/asc_pkg.sv
`default_nettype none
package asc_pkg;
   // Register index 0x93, byte address four times the index
   localparam logic [7:0]  STEP3_CFG_INDEX  = 8'h93;
   localparam logic [9:0]  STEP3_CFG_ADDR   = {STEP3_CFG_INDEX, 2'b00};
   localparam logic [15:0] STEP3_CFG_RESET  = 16'h0003;
   localparam int          EN_POS           = 15;
   localparam int          GAIN_HI          = 14;
   localparam int          GAIN_LO          = 13;
   localparam int          NEG_POS          = 4;
   localparam int          POS_HI           = 3;
   localparam int          POS_LO           = 0;
   localparam logic [15:0] STEP3_WR_MASK    = 16'he01f;
   localparam logic [3:0]  POS_INTERNAL_MIN = 4'h8;
   localparam logic [3:0]  POS_TEMP_A       = 4'h8;
   localparam logic [3:0]  POS_SHORT        = 4'h9;
   localparam logic [3:0]  POS_TEST_DAC     = 4'ha;
   localparam logic [3:0]  POS_IO_DIV4      = 4'hc;
   localparam logic [3:0]  POS_CORE_DIV2    = 4'hd;
   localparam logic [3:0]  POS_ANALOG_POWER_INPUT_DIV103  = 4'he;
   localparam logic [3:0]  POS_DIGITAL_POWER_INPUT_DIV103  = 4'hf;
   // Negative-input routing codes
   localparam logic [1:0]  NEG_AGND         = 2'h0;
   localparam logic [1:0]  NEG_EXT7         = 2'h1;
   localparam logic [1:0]  NEG_AUTO         = 2'h2;
   // Gain multipliers
   localparam logic [2:0]  GAIN_X1          = 3'h1;
   localparam logic [2:0]  GAIN_X2          = 3'h2;
   localparam logic [2:0]  GAIN_X4          = 3'h4;
endpackage
`default_nettype wire

// >>> src/asc_step3_cfg.sv
// Overview of operation
// - Bit 15 enables step 3 in the sequence; resets to 0.
// - Gain code 00 gives 1, 01 gives 2, 10 and 11 give 4.
// - Negative select bit 4: 0 analog ground, 1 external input seven.
// - Positive code bits 3:0, codes 0-7 select external inputs; resets 0011.
// - Codes 1000 and up pick the negative input automatically.
// - Codes 1000, 1001, 1010 select temperature, short, test DAC.
// - Top codes select scaled supply monitors.
// - Register at index 0x93, reset value 0x0003.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module asc_step3_cfg
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   output logic             step3_enable_bit_o,
   output logic      [2:0]  step3_gain_o,
   output logic      [15:0] step3_pos_onehot_o,
   output logic      [1:0]  step3_neg_sel_o,
   output logic             step3_temp_a_o,
   output logic             step3_short_o,
   output logic             step3_test_dac_o,
   output logic      [3:0]  step3_supply_mon_o
);
   logic [1:0]  rst_sync_r;
   logic        rst_n;
   logic [15:0] cfg_r, cfg_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic        ack_r, ack_nxt, err_r, err_nxt;
   logic        en_r, en_nxt;
   logic [2:0]  gain_r, gain_nxt;
   logic [15:0] pos_r, pos_nxt;
   logic [1:0]  neg_r, neg_nxt;
   logic [6:0]  src_r, src_nxt;
   logic        hit, req;
   logic [15:0] wmask;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   asc_decode u_dec
   (
      .cfg_i        (cfg_r),
      .gain_o       (gain_nxt),
      .pos_onehot_o (pos_nxt),
      .neg_sel_o    (neg_nxt)
   );

   assign req   = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
   assign hit   = (wb_adr_i == asc_pkg::STEP3_CFG_ADDR);
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & asc_pkg::STEP3_WR_MASK;

   always_comb
   begin
      cfg_nxt = cfg_r;
      ack_nxt = 1'b0;
      err_nxt = 1'b0;
      dat_nxt = dat_r;
      if (req)
      begin
         ack_nxt = hit;
         err_nxt = !hit;
         if (hit && wb_we_i)
            cfg_nxt = (cfg_r & ~wmask) | (wb_dat_i[15:0] & wmask);
         dat_nxt = (hit && !wb_we_i) ? {16'h0000, cfg_r & asc_pkg::STEP3_WR_MASK} : 32'h0;
      end
   end

   always_comb
   begin
      en_nxt = cfg_r[asc_pkg::EN_POS];
      src_nxt[0] = pos_nxt[asc_pkg::POS_TEMP_A];
      src_nxt[1] = pos_nxt[asc_pkg::POS_SHORT];
      src_nxt[2] = pos_nxt[asc_pkg::POS_TEST_DAC];
      // Supply monitors, code 1011 maps to no source
      src_nxt[3] = pos_nxt[asc_pkg::POS_IO_DIV4];
      src_nxt[4] = pos_nxt[asc_pkg::POS_CORE_DIV2];
      src_nxt[5] = pos_nxt[asc_pkg::POS_ANALOG_POWER_INPUT_DIV103];
      src_nxt[6] = pos_nxt[asc_pkg::POS_DIGITAL_POWER_INPUT_DIV103];
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_r  <= asc_pkg::STEP3_CFG_RESET;
         dat_r  <= 32'h0;
         ack_r  <= 1'b0;
         err_r  <= 1'b0;
         en_r   <= 1'b0;
         gain_r <= asc_pkg::GAIN_X1;
         pos_r  <= 16'h0001 << asc_pkg::STEP3_CFG_RESET[asc_pkg::POS_HI:asc_pkg::POS_LO];
         neg_r  <= asc_pkg::NEG_AGND;
         src_r  <= 7'h00;
      end
      else
      begin
         cfg_r  <= cfg_nxt;
         dat_r  <= dat_nxt;
         ack_r  <= ack_nxt;
         err_r  <= err_nxt;
         en_r   <= en_nxt;
         gain_r <= gain_nxt;
         pos_r  <= pos_nxt;
         neg_r  <= neg_nxt;
         src_r  <= src_nxt;
      end
   end

   assign wb_dat_o           = dat_r;
   assign wb_ack_o           = ack_r;
   assign wb_err_o           = err_r;
   assign step3_enable_bit_o = en_r;
   assign step3_gain_o       = gain_r;
   // Not gated by enable; the sequencer must skip a disabled step
   assign step3_pos_onehot_o = pos_r;
   assign step3_neg_sel_o    = neg_r;
   assign step3_temp_a_o     = src_r[0];
   assign step3_short_o      = src_r[1];
   assign step3_test_dac_o   = src_r[2];
   assign step3_supply_mon_o = src_r[6:3];

   enable_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      1 ##1 1 |-> ##1 (en_r == $past(cfg_r[asc_pkg::EN_POS])))
      else $error("enable output wrong");
   en_write_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      req && hit && wb_we_i && wb_sel_i[1] |=> cfg_r[15] == $past(wb_dat_i[15]))
      else $error("enable bit not written");
   gain_one_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[14:13] == 2'h0 |=> gain_r == asc_pkg::GAIN_X1)
      else $error("gain not one");
   gain_four_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[14] |=> gain_r == asc_pkg::GAIN_X4)
      else $error("gain not four");
   gain_two_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[14:13] == 2'h1 |=> gain_r == asc_pkg::GAIN_X2)
      else $error("gain not two");
   gain_write_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      req && hit && wb_we_i && wb_sel_i[1] |=> cfg_r[14:13] == $past(wb_dat_i[14:13]))
      else $error("gain code not written");
   neg_agnd_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !cfg_r[3] && !cfg_r[4] |=> neg_r == asc_pkg::NEG_AGND)
      else $error("negative not ground");
   neg_ext_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !cfg_r[3] && cfg_r[4] |=> neg_r == asc_pkg::NEG_EXT7)
      else $error("negative not ext7");
   neg_write_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      req && hit && wb_we_i && wb_sel_i[0] |=> cfg_r[4] == $past(wb_dat_i[4]))
      else $error("negative select not written");
   neg_auto_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[3] |=> neg_r == asc_pkg::NEG_AUTO)
      else $error("negative not auto");
   pos_onehot_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      ##1 pos_r == (16'h0001 << $past(cfg_r[3:0])))
      else $error("positive select wrong");
   pos_write_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      req && hit && wb_we_i && wb_sel_i[0] |=> cfg_r[3:0] == $past(wb_dat_i[3:0]))
      else $error("positive code not written");
   ext_no_src_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !cfg_r[3] |=>
      !step3_temp_a_o && !step3_short_o && !step3_test_dac_o && step3_supply_mon_o == 4'h0)
      else $error("external input drives a source");
   temp_src_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[3:0] == asc_pkg::POS_TEMP_A |=> step3_temp_a_o && !step3_short_o)
      else $error("temperature source wrong");
   short_src_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[3:0] == asc_pkg::POS_SHORT |=> step3_short_o && !step3_temp_a_o)
      else $error("short source wrong");
   test_dac_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[3:0] == asc_pkg::POS_TEST_DAC |=> step3_test_dac_o && !step3_temp_a_o)
      else $error("test source wrong");
   io_mon_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[3:0] == asc_pkg::POS_IO_DIV4 |=> step3_supply_mon_o == 4'h1)
      else $error("io supply monitor wrong");
   supply_mon_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[3:0] == asc_pkg::POS_DIGITAL_POWER_INPUT_DIV103 |=> step3_supply_mon_o == 4'h8)
      else $error("supply monitor wrong");
   reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg_r[12:5] == 8'h00 && dat_r[31:16] == 16'h0000 && dat_r[12:5] == 8'h00)
      else $error("reserved bits set");
   lane_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      req && hit && wb_we_i && !wb_sel_i[1] |=> cfg_r[15:13] == $past(cfg_r[15:13]))
      else $error("unselected lane written");
   read_back_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      req && hit && !wb_we_i |=> wb_dat_o == {16'h0000, $past(cfg_r)})
      else $error("read data wrong");
   reset_val_a: assert property (@(posedge clk_i)
      $rose(rst_n) |-> cfg_r == asc_pkg::STEP3_CFG_RESET)
      else $error("reset value wrong");
   ack_mapped_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      req && hit |=> ack_r && !err_r)
      else $error("mapped access not acknowledged");
   err_unmapped_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      req && !hit |=> err_r && !ack_r && wb_dat_o == 32'h0)
      else $error("unmapped access not refused");
   err_no_write_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      req && !hit |=> cfg_r == $past(cfg_r))
      else $error("unmapped access wrote register");
   ack_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      ack_r || err_r |=> !ack_r && !err_r)
      else $error("answer longer than one cycle");
   cover_write_c: cover property (@(posedge clk_i) ack_r && $past(wb_we_i));
   cover_err_c:   cover property (@(posedge clk_i) err_r);
   cover_en_c:    cover property (@(posedge clk_i) en_r && neg_r == asc_pkg::NEG_AUTO);
   cover_short_c: cover property (@(posedge clk_i) step3_short_o);
   cover_lane_c:  cover property (@(posedge clk_i) ack_r && $past(wb_sel_i) == 4'h1);
endmodule
`default_nettype wire

// >>> tb/asc_step3_cfg_test.sv
`timescale 1ns/1ns
`default_nettype none
module asc_step3_cfg_test;
   logic        clk_i    = 1'b0;
   logic        resetn_i = 1'b0;
   logic        cyc      = 1'b0;
   logic        we       = 1'b0;
   logic [9:0]  adr      = 10'h000;
   logic [31:0] wdat     = 32'h0;
   logic [3:0]  sel      = 4'h3;
   logic [9:0]  ra       = asc_pkg::STEP3_CFG_ADDR;
   logic [31:0] rdat;
   logic        ack;
   logic        err;
   logic        en;
   logic [2:0]  gain;
   logic [15:0] pos;
   logic [1:0]  neg;
   logic [2:0]  src;
   logic [3:0]  mon;
   logic [31:0] rd;
   logic        re;
   int          num_errors = 0;
   int          compares   = 0;

   asc_step3_cfg DUT
   (
      .clk_i              (clk_i),
      .resetn_i           (resetn_i),
      .wb_cyc_i           (cyc),
      .wb_stb_i           (cyc),
      .wb_we_i            (we),
      .wb_adr_i           (adr),
      .wb_sel_i           (sel),
      .wb_dat_i           (wdat),
      .wb_dat_o           (rdat),
      .wb_ack_o           (ack),
      .wb_err_o           (err),
      .step3_enable_bit_o (en),
      .step3_gain_o       (gain),
      .step3_pos_onehot_o (pos),
      .step3_neg_sel_o    (neg),
      .step3_temp_a_o     (src[2]),
      .step3_short_o      (src[1]),
      .step3_test_dac_o   (src[0]),
      .step3_supply_mon_o (mon)
   );

   always #25 clk_i = ~clk_i;

   task automatic complete_run();
      $display("num_errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Called just after a rising edge; holds the request until ack or err
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      rd = rdat;
      re = err;
      cyc <= 1'b0;
      if (ack !== 1'b1 && err !== 1'b1)
      begin
         num_errors++;
         complete_run();
      end
      @(posedge clk_i);
   endtask

   // Decoded outputs trail the register by a cycle
   task automatic settle();
      @(posedge clk_i);
   endtask

   initial
   begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      xfer(1'b0, ra, 32'h0);
      chk("reset value", rd, 32'h0000_0003);
      chk("reset decode", {en, gain, pos, neg}, {1'b0, 3'h1, 16'h0008, 2'h0});
      xfer(1'b0, ra ^ 10'h004, 32'h0);
      chk("unmapped err", {31'h0, re}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      xfer(1'b1, ra, 32'hffff_ffff);
      xfer(1'b0, ra, 32'h0);
      chk("reserved bits", rd, 32'h0000_e01f);
      // Byte lanes and a refused unmapped write
      sel <= 4'h1;
      xfer(1'b1, ra, 32'h0);
      xfer(1'b0, ra, 32'h0);
      chk("low lane", rd, 32'h0000_e000);
      sel <= 4'hc;
      xfer(1'b1, ra, 32'h0);
      sel <= 4'h2;
      xfer(1'b0, ra, 32'h0);
      chk("upper lanes", rd, 32'h0000_e000);
      xfer(1'b1, ra, 32'h0000_2000);
      sel <= 4'h3;
      xfer(1'b1, ra ^ 10'h004, 32'hffff_ffff);
      xfer(1'b0, ra, 32'h0);
      chk("unmapped write", rd, 32'h0000_2000);
      chk("lane gain", gain, 3'h2);
      for (int g = 0; g < 4; g++)
      begin
         xfer(1'b1, ra, {16'h0, 1'b1, g[1:0], 13'h0});
         settle();
         chk("gain", gain, (g == 0) ? 3'h1 : (g == 1) ? 3'h2 : 3'h4);
         chk("enable on", en, 1'b1);
      end
      // Every positive code with both negative selects
      for (int c = 0; c < 16; c++)
      begin
         for (int n = 0; n < 2; n++)
         begin
            xfer(1'b1, ra, {27'h0, n[0], c[3:0]});
            settle();
            chk("enable off", en, 1'b0);
            chk("pos onehot", pos, 16'h0001 << c);
            chk("neg sel", neg, (c >= 8) ? 2'h2 : {1'b0, n[0]});
            chk("sources", src, {c == 8, c == 9, c == 10});
            chk("supply mon", mon, (c >= 12) ? 4'h1 << (c - 12) : 4'h0);
            xfer(1'b0, ra, 32'h0);
            chk("readback", rd, {27'h0, n[0], c[3:0]});
         end
      end
      // Reset in mid-run restores the register
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      xfer(1'b0, ra, 32'h0);
      chk("reset again", rd, 32'h0000_0003);
      chk("reset again decode", {en, gain, pos, neg}, {1'b0, 3'h1, 16'h0008, 2'h0});
      complete_run();
   end
endmodule
`default_nettype wire
